// [hw/ocr_pkg.sv]
// shared constants, command codes and state encoding for the over-current fault response block
`default_nettype none

package ocr_pkg;
  // ***************************************************
  // command codes
  // ***************************************************
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_OC_LIMIT = 8'h46;
  localparam logic [7:0] CMD_OC_RESP = 8'h47;
  localparam logic [7:0] CMD_OC_LV_LIMIT = 8'h48;
  localparam logic [7:0] CMD_STATUS_IOUT = 8'h7B;
  localparam int STAT_OC_BIT = 7;

  // ***************************************************
  // response byte fields
  // ***************************************************
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;
  localparam logic [1:0] MODE_BRICKWALL = 2'h0;
  localparam logic [1:0] MODE_COND = 2'h1;
  localparam logic [1:0] MODE_DELAY = 2'h2;
  localparam logic [1:0] MODE_SHUTDOWN = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // ***************************************************
  // reset values and numeric format
  // ***************************************************
  localparam logic [15:0] RST_OC_LIMIT = 16'h7BFF;
  localparam logic [7:0] RST_OC_RESP = 8'hC0;
  localparam logic [15:0] RST_OC_LV = 16'h0000;
  localparam int LIN_EXP_HI = 15;
  localparam int LIN_EXP_LO = 11;
  localparam int LIN_MANT_HI = 10;
  localparam int FIX_FRAC = 16;

  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_RUN = 5'h02,
    ST_LIMIT = 5'h04,
    ST_WAIT = 5'h08,
    ST_LATCH = 5'h10
  } ocr_state_e;
endpackage

`default_nettype wire

// [hw/ocr_tmr_if.sv]
// handshake between the fault sequencer and its delay timer
`default_nettype none

interface ocr_tmr_if;
  logic start;
  logic run;
  logic [2:0] code;
  logic [15:0] unit;
  logic done;
  modport seq (output start, output run, output code, output unit, input done);
  modport tmr (input start, input run, input code, input unit, output done);
endinterface

`default_nettype wire

// [hw/ocr_timer.sv]
// delay timer: 2^code time units, each unit a programmable number of clock cycles
`default_nettype none

module ocr_timer
  import ocr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  ocr_tmr_if.tmr t
);
  logic busy_reg, busy_next;
  logic [15:0] unit_cnt_reg, unit_cnt_next;
  logic [7:0] units_reg, units_next;
  logic [15:0] unit_m1;
  logic [23:0] el_reg, exp_reg;

  // a zero unit length would never tick, so it counts as one cycle
  assign unit_m1 = (t.unit == 16'h0000) ? 16'h0000 : t.unit - 16'h0001;
  // the unit divider gives the tick, the unit counter gives the length
  // done comes from registers alone: run is decoded from the sequencer's next state, which reads done
  assign t.done = busy_reg && unit_cnt_reg == 16'h0000 && units_reg == 8'h00;

  // ***************************************************
  // divider and unit count
  // ***************************************************
  always_comb begin
    busy_next = busy_reg;
    unit_cnt_next = unit_cnt_reg;
    units_next = units_reg;
    if (t.start) begin
      busy_next = 1'b1;
      unit_cnt_next = unit_m1;
      units_next = 8'((9'h001 << t.code) - 9'h001);
    end else if (!t.run || t.done) begin
      busy_next = 1'b0; // dropping run abandons the count
    end else if (busy_reg) begin
      if (unit_cnt_reg == 16'h0000) begin
        unit_cnt_next = unit_m1;
        units_next = units_reg - 8'h01;
      end else begin
        unit_cnt_next = unit_cnt_reg - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      unit_cnt_reg <= 16'h0000;
      units_reg <= 8'h00;
    end else begin
      busy_reg <= busy_next;
      unit_cnt_reg <= unit_cnt_next;
      units_reg <= units_next;
    end
  end

  // helper for the length check only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      el_reg <= 24'h000000;
      exp_reg <= 24'h000000;
    end else if (t.start) begin
      el_reg <= 24'h000001;
      exp_reg <= 24'({8'h00, unit_m1 + 16'h0001} << t.code);
    end else begin
      el_reg <= el_reg + 24'h000001;
    end
  end

  a_delay_length: assert property (@(posedge clk) disable iff (!rst_n) t.done |-> el_reg == exp_reg)
    else $error("delay length differs from code times unit");
endmodule

`default_nettype wire

// [hw/ocr_fault_resp.sv]
// over-current fault response: threshold compare, response modes, retry sequencer, command port
`default_nettype none

module ocr_fault_resp
  import ocr_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic CMD_WR,
  input wire logic CMD_RD,
  input wire logic [7:0] CMD_CODE,
  input wire logic [15:0] CMD_DATA,
  input wire logic [15:0] IOUT_MEAS,
  input wire logic [15:0] VOUT_MEAS,
  input wire logic [15:0] DELAY_UNIT,
  input wire logic ON_CMD,
  input wire logic OTHER_FAULT,
  output logic OUT_ENABLE,
  output logic CURR_LIMIT,
  output logic OC_FAULT,
  output logic HOST_ALERT_N,
  output logic [15:0] RD_DATA,
  output logic RD_ACK
);
  ocr_tmr_if tif ();

  logic [15:0] limit_reg, limit_next;
  logic [7:0] resp_reg, resp_next;
  logic [15:0] lv_reg, lv_next;
  ocr_state_e state_reg, state_next;
  logic [2:0] attempt_reg, attempt_next;
  logic fault_reg, fault_next;
  logic alert_n_reg, alert_n_next;
  logic on_prev_reg;
  logic out_en_reg, out_en_next;
  logic ilim_reg, ilim_next;
  logic [15:0] rd_data_reg, rd_data_next;
  logic rd_ack_reg;
  logic oc, low_v, fault_clear, shut, tmr_start;
  logic [1:0] mode;
  logic [2:0] retries;

  // ***************************************************
  // threshold comparison
  // ***************************************************
  // linear values are scaled to one fixed-point grid so differing exponents compare right
  function automatic logic signed [47:0] lin_to_fix(input logic [15:0] v);
    logic [5:0] sh;
    logic signed [47:0] m;
    sh = 6'(signed'(v[LIN_EXP_HI:LIN_EXP_LO])) + 6'(FIX_FRAC);
    m = 48'(signed'(v[LIN_MANT_HI:0]));
    lin_to_fix = m <<< sh;
  endfunction

  // measured current and voltage against the held limits
  assign oc = lin_to_fix(IOUT_MEAS) > lin_to_fix(limit_reg);
  assign low_v = VOUT_MEAS < lv_reg;
  assign mode = resp_reg[MODE_HI:MODE_LO];
  assign retries = resp_reg[RETRY_HI:RETRY_LO];
  // status write-one-to-clear, clear-faults, or an off-to-on edge of the output command
  assign fault_clear = (CMD_WR && CMD_CODE == CMD_STATUS_IOUT && CMD_DATA[STAT_OC_BIT]) ||
                       (CMD_WR && CMD_CODE == CMD_CLEAR_FAULTS) || (ON_CMD && !on_prev_reg);

  // ***************************************************
  // command registers and readback
  // ***************************************************
  always_comb begin
    limit_next = limit_reg;
    resp_next = resp_reg;
    lv_next = lv_reg;
    rd_data_next = rd_data_reg;
    if (CMD_WR) begin
      case (CMD_CODE)
        CMD_OC_LIMIT: limit_next = CMD_DATA;
        CMD_OC_RESP: resp_next = CMD_DATA[7:0];
        CMD_OC_LV_LIMIT: lv_next = CMD_DATA;
        default: ;
      endcase
    end
    if (CMD_RD) begin
      case (CMD_CODE)
        CMD_OC_LIMIT: rd_data_next = limit_reg;
        CMD_OC_RESP: rd_data_next = {8'h00, resp_reg};
        CMD_OC_LV_LIMIT: rd_data_next = lv_reg;
        CMD_STATUS_IOUT: begin
          rd_data_next = 16'h0000;
          rd_data_next[STAT_OC_BIT] = fault_reg;
        end
        default: rd_data_next = 16'h0000; // unknown codes read as zero
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      limit_reg <= RST_OC_LIMIT;
      resp_reg <= RST_OC_RESP;
      lv_reg <= RST_OC_LV;
      rd_data_reg <= 16'h0000;
      rd_ack_reg <= 1'b0;
    end else begin
      limit_reg <= limit_next;
      resp_reg <= resp_next;
      lv_reg <= lv_next;
      rd_data_reg <= rd_data_next;
      rd_ack_reg <= CMD_RD;
    end
  end

  // ***************************************************
  // response sequencer
  // ***************************************************
  always_comb begin
    state_next = state_reg;
    attempt_next = attempt_reg;
    shut = 1'b0;
    tmr_start = 1'b0;
    case (state_reg)
      ST_OFF: begin
        if (ON_CMD) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (oc) begin
          case (mode)
            MODE_BRICKWALL: ;
            MODE_COND: shut = low_v;
            MODE_DELAY: begin
              state_next = ST_LIMIT;
              tmr_start = 1'b1;
            end
            default: shut = 1'b1;
          endcase
        end
      end
      ST_LIMIT: begin
        if (!oc) begin
          state_next = ST_RUN;
        end else if (tif.done) begin
          shut = 1'b1;
        end
      end
      ST_WAIT: begin
        if (tif.done) begin
          state_next = ST_RUN;
          if (retries != RETRY_FOREVER) begin
            attempt_next = attempt_reg + 3'h1;
          end
        end
      end
      ST_LATCH: begin
        if (fault_clear) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_OFF;
    endcase
    // a shutdown either waits for the next attempt or latches off once attempts run out
    if (shut) begin
      if (retries == RETRY_NONE) begin
        state_next = ST_LATCH;
      // at or beyond the count latches, so lowering the field mid-sequence grants no extra attempt
      end else if (retries != RETRY_FOREVER && attempt_reg >= retries) begin
        state_next = ST_LATCH;
      end else begin
        state_next = ST_WAIT;
        tmr_start = 1'b1;
      end
    end
    if (fault_clear) begin
      attempt_next = 3'h0;
    end
    // off command and foreign faults override everything, even endless retrying
    if (!ON_CMD) begin
      state_next = ST_OFF;
    end else if (OTHER_FAULT) begin
      state_next = ST_LATCH;
    end
  end

  // timer runs only while limiting or waiting; leaving either abandons it
  assign tif.run = state_next == ST_LIMIT || state_next == ST_WAIT;
  assign tif.start = tmr_start && tif.run;
  assign tif.code = resp_reg[DELAY_HI:DELAY_LO];
  assign tif.unit = DELAY_UNIT;

  ocr_timer u_timer (
    .clk(REF_CLK),
    .rst_n(NRST),
    .t(tif.tmr)
  );

  // ***************************************************
  // status, notification and output drive
  // ***************************************************
  always_comb begin
    out_en_next = state_next == ST_RUN || state_next == ST_LIMIT;
    // current regulation holds whenever running and over the limit
    ilim_next = out_en_next && oc;
    // a new crossing wins over a clear in the same cycle
    fault_next = (oc && out_en_reg) || (fault_reg && !fault_clear);
    alert_n_next = !fault_next;
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= ST_OFF;
      attempt_reg <= 3'h0;
      fault_reg <= 1'b0;
      alert_n_reg <= 1'b1;
      on_prev_reg <= 1'b0;
      out_en_reg <= 1'b0;
      ilim_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      attempt_reg <= attempt_next;
      fault_reg <= fault_next;
      alert_n_reg <= alert_n_next;
      on_prev_reg <= ON_CMD;
      out_en_reg <= out_en_next;
      ilim_reg <= ilim_next;
    end
  end

  assign OUT_ENABLE = out_en_reg;
  assign CURR_LIMIT = ilim_reg;
  assign OC_FAULT = fault_reg;
  assign HOST_ALERT_N = alert_n_reg;
  assign RD_DATA = rd_data_reg;
  assign RD_ACK = rd_ack_reg;

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);

  logic quiet;
  assign quiet = ON_CMD && !OTHER_FAULT;

  sequence s_delay_entry;
    state_reg == ST_RUN && oc && mode == MODE_DELAY && quiet;
  endsequence

  sequence s_hard_trip;
    state_reg == ST_RUN && oc && mode == MODE_SHUTDOWN && quiet;
  endsequence

  a_fault_sets: assert property (oc && out_en_reg |=> fault_reg)
    else $error("crossing did not set the fault bit");
  a_alert_tracks: assert property (fault_reg |-> !HOST_ALERT_N)
    else $error("fault without host alert");
  a_brickwall_runs: assert property (state_reg == ST_RUN && mode == MODE_BRICKWALL && quiet
                                     |=> out_en_reg && state_reg == ST_RUN)
    else $error("brickwall mode left run");
  a_cond_shuts: assert property (state_reg == ST_RUN && oc && mode == MODE_COND && low_v && quiet
                                 |=> !out_en_reg)
    else $error("conditioned mode kept running at low voltage");
  a_delay_enters: assert property (s_delay_entry |=> state_reg == ST_LIMIT && out_en_reg)
    else $error("delay mode did not start limiting");
  a_limit_abandon: assert property (state_reg == ST_LIMIT && !oc && quiet |=> state_reg == ST_RUN)
    else $error("delay not abandoned when oc ended");
  a_hard_trip: assert property (s_hard_trip ##1 1'b1 |-> !out_en_reg)
    else $error("shutdown mode kept output on");
  a_no_retry: assert property (state_reg == ST_LATCH && !fault_clear && quiet
                               |=> state_reg == ST_LATCH && !out_en_reg)
    else $error("latched off state left without clear");
  // judged on entry with the field that made the decision, so a later rewrite cannot trip it
  a_attempt_bound: assert property (state_reg == ST_WAIT && $past(state_reg) != ST_WAIT
                                    && $past(retries) != RETRY_FOREVER |-> attempt_reg < $past(retries))
    else $error("waiting beyond the retry count");
  a_forever_retry: assert property ((s_hard_trip and (retries == RETRY_FOREVER)) |=> state_reg == ST_WAIT)
    else $error("endless retry latched off");
  a_clear_resets: assert property (fault_clear && !(oc && out_en_reg)
                                   |=> !fault_reg && attempt_reg == 3'h0)
    else $error("clear left fault or attempt count");
  // off command and foreign faults win over every response mode
  a_off_stops: assert property (!ON_CMD |=> state_reg == ST_OFF && !out_en_reg)
    else $error("off command left the output on");
  a_other_latches: assert property (ON_CMD && OTHER_FAULT |=> state_reg == ST_LATCH && !out_en_reg)
    else $error("foreign fault did not latch the output off");
endmodule

`default_nettype wire

// [testbench/ocr_host_model.sv]
// host-side command model: register writes, reads and fault clears
`default_nettype none

module ocr_host_model
  import ocr_pkg::*;
(
  input wire logic clk,
  output var logic cmd_wr,
  output var logic cmd_rd,
  output var logic [7:0] cmd_code,
  output var logic [15:0] cmd_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    cmd_data = 16'h0000;
  end

  // one strobe cycle; afterwards code and data show inverted values so stale words never look valid
  task automatic xfer(input logic w, input logic [7:0] code, input logic [15:0] data);
    @(posedge clk);
    cmd_wr <= w;
    cmd_rd <= ~w;
    cmd_code <= code;
    cmd_data <= data;
    @(posedge clk);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    cmd_code <= ~code;
    cmd_data <= ~data;
  endtask

  // clear-faults command
  task automatic clr();
    xfer(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
  endtask
endmodule

`default_nettype wire

// [testbench/test_overcurrent_fault_response.sv]
// self-checking bench for the over-current fault response block
`default_nettype none

module test_overcurrent_fault_response
  import ocr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] LIM = 16'h0064;
  localparam logic [15:0] HI = 16'h00C8;
  logic ref_clk, nrst, cmd_wr, cmd_rd, on_cmd, other, oe, climit, ocf, alert_n, rd_ack, oe_d;
  logic [7:0] cmd_code;
  logic [15:0] cmd_data, iout, vout, unit, rd_data, d;
  logic [15:0] exp_q[$];
  int n_mismatch, total_checks, cyc, n_rise, t_rise, per, per0, seed;

  ocr_host_model host (.clk(ref_clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
    .cmd_data(cmd_data));

  ocr_fault_resp uut (.REF_CLK(ref_clk), .NRST(nrst), .CMD_WR(cmd_wr), .CMD_RD(cmd_rd),
    .CMD_CODE(cmd_code), .CMD_DATA(cmd_data), .IOUT_MEAS(iout), .VOUT_MEAS(vout),
    .DELAY_UNIT(unit), .ON_CMD(on_cmd), .OTHER_FAULT(other), .OUT_ENABLE(oe), .CURR_LIMIT(climit),
    .OC_FAULT(ocf), .HOST_ALERT_N(alert_n), .RD_DATA(rd_data), .RD_ACK(rd_ack));

  // ********************
  // helpers
  // ********************

  // 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // note the expected word first, so the watcher can pair it with the answer
  task automatic rd(input logic [7:0] code, input logic [15:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, code, 16'h0000);
  endtask

  // fresh start: new response byte, random current below the limit, faults cleared
  task automatic arm(input logic [7:0] resp);
    host.xfer(1'b1, CMD_OC_RESP, {8'h00, resp});
    iout <= 16'($random(seed)) & 16'h003F;
    other <= 1'b0;
    on_cmd <= 1'b1;
    host.clr();
    cycles(4);
    n_rise = 0;
  endtask

  // watcher: read answers, restart edges and the hang limit
  always @(posedge ref_clk) begin
    cyc++;
    if (rd_ack === 1'b1) begin
      if (exp_q.size() > 0) begin
        chk(rd_data, exp_q.pop_front());
      end else begin
        chk(rd_data, ~rd_data);
      end
    end
    if (oe === 1'b1 && oe_d !== 1'b1) begin
      per = cyc - t_rise;
      t_rise = cyc;
      n_rise++;
    end
    oe_d = oe;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // main sequence
  initial begin
    seed = 18;
    {n_mismatch, total_checks, cyc, n_rise, t_rise, per, per0} = '0;
    {nrst, other, oe_d} = 3'h0;
    on_cmd = 1'b1;
    iout = 16'h0000;
    vout = 16'h2000;
    unit = 16'h0001;
    cycles(20);
    nrst <= 1'b1;
    rd(CMD_OC_LIMIT, RST_OC_LIMIT);
    rd(CMD_OC_RESP, {8'h00, RST_OC_RESP});
    rd(CMD_OC_LV_LIMIT, RST_OC_LV);
    rd(8'h20, 16'h0000);
    repeat (3) begin
      d = 16'($random(seed));
      host.xfer(1'b1, CMD_OC_LIMIT, d);
      rd(CMD_OC_LIMIT, d);
      host.xfer(1'b1, CMD_OC_RESP, d);
      rd(CMD_OC_RESP, {8'h00, d[7:0]});
      host.xfer(1'b1, CMD_OC_LV_LIMIT, d);
      rd(CMD_OC_LV_LIMIT, d);
    end
    host.xfer(1'b1, CMD_OC_LIMIT, LIM);
    host.xfer(1'b1, CMD_OC_LV_LIMIT, 16'h1000);
    // brickwall: flag and alert, never off; then clear the status bit alone
    arm({MODE_BRICKWALL, RETRY_FOREVER, 3'h0});
    iout <= HI;
    cycles(200);
    chk(16'(oe), 16'h0001);
    chk(16'(climit), 16'h0001);
    chk(16'(alert_n), 16'h0000);
    rd(CMD_STATUS_IOUT, 16'h0080);
    iout <= 16'h0010;
    cycles(2);
    host.xfer(1'b1, CMD_STATUS_IOUT, 16'h0080);
    rd(CMD_STATUS_IOUT, 16'h0000);
    // conditioned: off only once voltage sags, no retry
    arm({MODE_COND, RETRY_NONE, 3'h0});
    iout <= HI;
    cycles(30);
    chk(16'(oe), 16'h0001);
    vout <= 16'h0800;
    cycles(60);
    chk(16'(oe), 16'h0000);
    chk(16'(n_rise), 16'h0000);
    vout <= 16'h2000;
    // delayed: 8 units of 2 cycles, a short burst must not shut down
    unit <= 16'h0002;
    arm({MODE_DELAY, RETRY_NONE, 3'h3});
    iout <= HI;
    cycles(10);
    iout <= 16'h0010;
    cycles(3);
    chk(16'(oe), 16'h0001);
    chk(16'(climit), 16'h0000);
    iout <= HI;
    cycles(14);
    chk(16'(oe), 16'h0001);
    cycles(6);
    chk(16'(oe), 16'h0000);
    // shutdown mode: every finite retry count
    for (int r = 0; r < 7; r++) begin
      arm({MODE_SHUTDOWN, 3'(r), 3'h0});
      iout <= HI;
      cycles(150);
      chk(16'(n_rise), 16'(r));
      chk(16'(oe), 16'h0000);
      rd(CMD_STATUS_IOUT, 16'h0080);
    end
    // endless retry, stopped by another fault
    arm({MODE_SHUTDOWN, RETRY_FOREVER, 3'h0});
    iout <= HI;
    cycles(150);
    chk(16'(n_rise > 10), 16'h0001);
    other <= 1'b1;
    cycles(3);
    n_rise = 0;
    cycles(40);
    chk(16'(n_rise), 16'h0000);
    // retry interval grows by powers of two; off command stops it, off-then-on clears
    for (int c = 0; c < 8; c++) begin
      arm({MODE_SHUTDOWN, RETRY_FOREVER, 3'(c)});
      iout <= HI;
      for (int k = 0; k < 1000 && n_rise < 3; k++) cycles(1);
      chk(16'(n_rise), 16'h0003);
      if (c == 0) per0 = per;
      chk(16'(per - per0), 16'((2 ** c - 1) * 2));
      on_cmd <= 1'b0;
      iout <= 16'h0010;
      cycles(3);
      chk(16'(oe), 16'h0000);
      on_cmd <= 1'b1;
      cycles(3);
      rd(CMD_STATUS_IOUT, 16'h0000);
    end
    // mid-run reset clears a latched fault and restores the limit
    arm({MODE_SHUTDOWN, RETRY_NONE, 3'h0});
    iout <= HI;
    cycles(4);
    chk(16'(ocf), 16'h0001);
    nrst <= 1'b0;
    cycles(2);
    chk(16'(ocf), 16'h0000);
    chk(16'(alert_n), 16'h0001);
    iout <= 16'h0000;
    nrst <= 1'b1;
    rd(CMD_OC_LIMIT, RST_OC_LIMIT);
    cycles(5);
    chk(16'(exp_q.size()), 16'h0000);
    stop_test();
  end
endmodule

`default_nettype wire
